// ==== rtl/irq_priority_consts.vh ====
// Constants for the interrupt priority unit: register map, fields, vectors, timing
`ifndef IRQ_PRIORITY_CONSTS_VH
`define IRQ_PRIORITY_CONSTS_VH

// Printed register indices; byte address is four times the index
`define IDX_TIMER_CONTROL   8'h88
`define IDX_IRQ_ENABLE      8'ha8
`define IDX_SECOND_EN_PRIO  8'ha9
`define IDX_IRQ_PRIORITY    8'hb8
`define IDX_IRQ_STATUS      8'hc8
`define ADDR_WIDTH          10

// Reset values
`define RST_IRQ_ENABLE      8'h00
`define RST_IRQ_PRIORITY    8'h00
`define RST_SECOND_EN_PRIO  8'ha0
`define RST_TIMER_CONTROL   8'h00

// Main enable register fields
`define BIT_GLOBAL_EN       7
`define BIT_TEMP_EN         6
`define BIT_TMR2_EN         5
`define BIT_UART_EN         4
`define BIT_TMR1_EN         3
`define BIT_EXT1_EN         2
`define BIT_TMR0_EN         1
`define BIT_EXT0_EN         0

// Main priority register fields
`define BIT_METER_PRIO      7
`define BIT_TEMP_PRIO       6
`define BIT_TMR2_PRIO       5
`define BIT_UART_PRIO       4
`define BIT_TMR1_PRIO       3
`define BIT_EXT1_PRIO       2
`define BIT_TMR0_PRIO       1
`define BIT_EXT0_PRIO       0

// Second enable/priority register fields
`define BIT_UART_B_PRIO     7
`define BIT_RTC_PRIO        6
`define BIT_UART_B_EN       5
`define BIT_SERIAL_PRIO     4
`define BIT_METER_EN        3
`define BIT_RTC_EN          2
`define BIT_POWER_EN        1
`define BIT_SERIAL_EN       0

// Timer control register fields
`define BIT_TMR1_OVF        7
`define BIT_TMR0_OVF        5
`define BIT_EXT1_PEND       3
`define BIT_EXT1_EDGE       2
`define BIT_EXT0_PEND       1
`define BIT_EXT0_EDGE       0

// Vector table
`define VECTOR_BASE         16'h0003
`define VECTOR_STEP         16'h0008

// Latency: least time from request to vector
`define MIN_LATENCY_NS      800
`define CLK_PERIOD_NS       4

`endif

// ==== rtl/irq_priority_unit.v ====
// Interrupt priority unit: masking, three-level ranking, vectors and clearing
//
// Behaviour
// - Second register priority bits 7, 6, 4
// - Second register enable bits 5,3,2,1,0
// - Equal level served in fixed polling order
// - Power management alone at top level
// - Pending flags at documented bit positions
// - Temperature request has no visible flag
// - Wake-up from core-off makes external pending
// - Core-off events leave external flags unchanged
// - Temperature and serial requests latched until entry
// - RTC request follows alarm/interval flags
// - Multi-source requests not cleared on entry
// - External request auto-cleared only edge mode
// - Low-level external request re-enters until high
// - Push counter and load vector on entry
// - Vectors every 8 bytes from 0x0003
// - Block vectoring one instruction after return/access
// - Latency at least 3.25 instruction cycles
// - Only program counter saved on vectoring
// - High preempts low, never same level
// - Global enable gates every source
`include "irq_priority_consts.vh"

module irq_priority_unit #(
    parameter NUM_SRC = 13,
    parameter MIN_LAT = (`MIN_LATENCY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
    input  wire                   clk,
    input  wire                   rst_b,
    // Avalon-MM slave
    input  wire [`ADDR_WIDTH-1:0] address,
    input  wire [3:0]             byteenable,
    input  wire                   read,
    input  wire                   write,
    input  wire [31:0]            writedata,
    output reg  [31:0]            readdata,
    output reg                    waitrequest,
    // Peripheral request sources (core clock)
    input  wire                   power_mgmt_flag,
    input  wire                   rtc_alarm_flag,
    input  wire                   rtc_interval_flag,
    input  wire                   metering_irq_flag,
    input  wire                   watchdog_timeout_flag,
    input  wire                   temperature_request,
    input  wire                   serial_periph_request,
    input  wire                   timer0_overflow,
    input  wire                   timer1_overflow,
    input  wire                   timer2_overflow,
    input  wire                   timer2_external_flag,
    input  wire                   uart_receive_flag,
    input  wire                   uart_transmit_flag,
    input  wire                   uart_b_receive_flag,
    input  wire                   uart_b_transmit_flag,
    // External interrupt pins, active low, asynchronous
    input  wire                   ext_pin0_b,
    input  wire                   ext_pin1_b,
    // Power mode and wake-up events
    input  wire                   core_off_power_mode,
    input  wire                   ext_wake0,
    input  wire                   ext_wake1,
    // Core sequencing
    input  wire                   instr_done,
    input  wire                   return_from_interrupt,
    output reg                    vectorTake,
    output reg  [15:0]            vectorAddr
);

    // Polling order indices, 0 is highest
    localparam P_POWER = 0;
    localparam P_RTC   = 1;
    localparam P_METER = 2;
    localparam P_WDOG  = 3;
    localparam P_TEMP  = 4;
    localparam P_EXT0  = 5;
    localparam P_TMR0  = 6;
    localparam P_EXT1  = 7;
    localparam P_TMR1  = 8;
    localparam P_SER   = 9;
    localparam P_UART  = 10;
    localparam P_TMR2  = 11;
    localparam P_UARTB = 12;

    // Vector slot for each polling index, in vector table order
    function [3:0] vecSlot;
        input [3:0] idx;
        begin
            case (idx)
                4'h0:    vecSlot = 4'h8;
                4'h1:    vecSlot = 4'ha;
                4'h2:    vecSlot = 4'h9;
                4'h3:    vecSlot = 4'hb;
                4'h4:    vecSlot = 4'h6;
                4'h5:    vecSlot = 4'h0;
                4'h6:    vecSlot = 4'h1;
                4'h7:    vecSlot = 4'h2;
                4'h8:    vecSlot = 4'h3;
                4'h9:    vecSlot = 4'h7;
                4'ha:    vecSlot = 4'h4;
                4'hb:    vecSlot = 4'h5;
                default: vecSlot = 4'hc;
            endcase
        end
    endfunction

    // Software-visible registers
    reg  [7:0]  irqEnable;          // Main enable register
    reg  [7:0]  irqPriority;        // Main priority register
    reg  [7:0]  secondEnablePrio;   // Second enable/priority register
    reg  [7:0]  timerControl;       // Timer control: trigger types and flags

    // Internal state
    reg         pin0Meta;           // First sync stage, pin 0
    reg         pin0Sync;           // Second sync stage, pin 0
    reg         pin1Meta;           // First sync stage, pin 1
    reg         pin1Sync;           // Second sync stage, pin 1
    reg         pin0Last;           // Previous synced level for edge detect
    reg         pin1Last;           // Previous synced level for edge detect
    reg         wake0Pend;          // Pending external 0 from wake-up
    reg         wake1Pend;          // Pending external 1 from wake-up
    reg         tempLatch;          // Latched temperature request
    reg         serLatch;           // Latched serial request
    reg  [2:0]  inService;          // One bit per level in service
    reg         holdOff;            // One-instruction vectoring block
    reg  [15:0] latCount;           // Cycles since an outranking request seen

    // Bus decode
    wire [7:0]  regIdx    = address[`ADDR_WIDTH-1:2];
    wire        wordAlign = (address[1:0] == 2'b00);
    wire        busDone   = (read | write) & ~waitrequest;
    wire        wrLow     = write & busDone & byteenable[0] & wordAlign;
    wire        wrEn      = wrLow & (regIdx == `IDX_IRQ_ENABLE);
    wire        wrPrio    = wrLow & (regIdx == `IDX_IRQ_PRIORITY);
    wire        wrSecond  = wrLow & (regIdx == `IDX_SECOND_EN_PRIO);
    wire        wrTimer   = wrLow & (regIdx == `IDX_TIMER_CONTROL);
    // Any completed access to an enable or priority register
    wire        cfgAccess = busDone & wordAlign & ((regIdx == `IDX_IRQ_ENABLE) |
                            (regIdx == `IDX_IRQ_PRIORITY) | (regIdx == `IDX_SECOND_EN_PRIO));

    // Falling edges of the synced pins, ignored while the core is off
    wire        fall0 = pin0Last & ~pin0Sync & ~core_off_power_mode;
    wire        fall1 = pin1Last & ~pin1Sync & ~core_off_power_mode;

    // Per-source request, enable and level
    reg  [NUM_SRC-1:0] request;
    reg  [NUM_SRC-1:0] enable;
    reg  [NUM_SRC-1:0] highPrio;
    wire [NUM_SRC-1:0] eligible;
    wire [1:0]         level [0:NUM_SRC-1];

    // Request and mask table in polling order
    always @* begin
        request           = {NUM_SRC{1'b0}};
        enable            = {NUM_SRC{1'b0}};
        highPrio          = {NUM_SRC{1'b0}};
        // Multi-source flags stay asserted until software clears them
        request[P_POWER]  = power_mgmt_flag;
        request[P_RTC]    = rtc_alarm_flag | rtc_interval_flag;
        request[P_METER]  = metering_irq_flag;
        request[P_WDOG]   = watchdog_timeout_flag;
        request[P_TEMP]   = tempLatch;
        // Level mode: request follows the low pin
        request[P_EXT0]   = timerControl[`BIT_EXT0_PEND] | wake0Pend;
        request[P_TMR0]   = timerControl[`BIT_TMR0_OVF];
        request[P_EXT1]   = timerControl[`BIT_EXT1_PEND] | wake1Pend;
        request[P_TMR1]   = timerControl[`BIT_TMR1_OVF];
        request[P_SER]    = serLatch;
        request[P_UART]   = uart_receive_flag | uart_transmit_flag;
        request[P_TMR2]   = timer2_overflow | timer2_external_flag;
        request[P_UARTB]  = uart_b_receive_flag | uart_b_transmit_flag;
        // Enable bits
        enable[P_POWER]   = secondEnablePrio[`BIT_POWER_EN];
        enable[P_RTC]     = secondEnablePrio[`BIT_RTC_EN];
        enable[P_METER]   = secondEnablePrio[`BIT_METER_EN];
        enable[P_WDOG]    = 1'b1;
        enable[P_TEMP]    = irqEnable[`BIT_TEMP_EN];
        enable[P_EXT0]    = irqEnable[`BIT_EXT0_EN];
        enable[P_TMR0]    = irqEnable[`BIT_TMR0_EN];
        enable[P_EXT1]    = irqEnable[`BIT_EXT1_EN];
        enable[P_TMR1]    = irqEnable[`BIT_TMR1_EN];
        enable[P_SER]     = secondEnablePrio[`BIT_SERIAL_EN];
        enable[P_UART]    = irqEnable[`BIT_UART_EN];
        enable[P_TMR2]    = irqEnable[`BIT_TMR2_EN];
        enable[P_UARTB]   = secondEnablePrio[`BIT_UART_B_EN];
        // Configurable priority bits; watchdog sits at the low level
        highPrio[P_RTC]   = secondEnablePrio[`BIT_RTC_PRIO];
        highPrio[P_METER] = irqPriority[`BIT_METER_PRIO];
        highPrio[P_TEMP]  = irqPriority[`BIT_TEMP_PRIO];
        highPrio[P_EXT0]  = irqPriority[`BIT_EXT0_PRIO];
        highPrio[P_TMR0]  = irqPriority[`BIT_TMR0_PRIO];
        highPrio[P_EXT1]  = irqPriority[`BIT_EXT1_PRIO];
        highPrio[P_TMR1]  = irqPriority[`BIT_TMR1_PRIO];
        highPrio[P_SER]   = secondEnablePrio[`BIT_SERIAL_PRIO];
        highPrio[P_UART]  = irqPriority[`BIT_UART_PRIO];
        highPrio[P_TMR2]  = irqPriority[`BIT_TMR2_PRIO];
        highPrio[P_UARTB] = secondEnablePrio[`BIT_UART_B_PRIO];
    end

    // Level and eligibility per source
    genvar g;
    generate
        for (g = 0; g < NUM_SRC; g = g + 1) begin : src
            // Power management alone on level 2
            assign level[g] = (g == P_POWER) ? 2'd2 : {1'b0, highPrio[g]};
            // Gated by own enable and the global enable
            assign eligible[g] = request[g] & enable[g] &
                                 irqEnable[`BIT_GLOBAL_EN];
        end
    endgenerate

    // Highest level present, then first in polling order
    reg  [3:0] winIdx;
    reg  [1:0] winLevel;
    reg        winValid;
    integer    i;
    always @* begin
        winIdx   = 4'h0;
        winLevel = 2'd0;
        winValid = 1'b0;
        // Walk from lowest to highest rank so the last hit wins
        for (i = NUM_SRC - 1; i >= 0; i = i - 1) begin
            if (eligible[i] && (!winValid || level[i] >= winLevel)) begin
                winIdx   = i[3:0];
                winLevel = level[i];
                winValid = 1'b1;
            end
        end
    end

    // Highest level currently in service, zero-based plus valid
    wire       anyService = |inService;
    wire [1:0] topService = inService[2] ? 2'd2 : (inService[1] ? 2'd1 : 2'd0);
    // Must strictly outrank any routine in service
    wire       outranks   = winValid & (!anyService || winLevel > topService);
    // Take only at an instruction boundary, after hold-off and least latency
    wire       takeNow    = outranks & instr_done & ~holdOff &
                            (latCount >= MIN_LAT[15:0]) & ~vectorTake;
    wire [15:0] nextVector = `VECTOR_BASE + {9'h000, vecSlot(winIdx), 3'b000};

    // Sources whose pending state clears on entry
    wire clrTemp = takeNow & (winIdx == P_TEMP);
    wire clrSer  = takeNow & (winIdx == P_SER);
    wire clrTmr0 = takeNow & (winIdx == P_TMR0);
    wire clrTmr1 = takeNow & (winIdx == P_TMR1);
    wire clrExt0 = takeNow & (winIdx == P_EXT0);
    wire clrExt1 = takeNow & (winIdx == P_EXT1);

    // Pin synchronisers and edge history
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pin0Meta <= 1'b1;
            pin0Sync <= 1'b1;
            pin1Meta <= 1'b1;
            pin1Sync <= 1'b1;
            pin0Last <= 1'b1;
            pin1Last <= 1'b1;
        end else begin
            pin0Meta <= ext_pin0_b;
            pin0Sync <= pin0Meta;
            pin1Meta <= ext_pin1_b;
            pin1Sync <= pin1Meta;
            pin0Last <= pin0Sync;
            pin1Last <= pin1Sync;
        end
    end

    // Enable and priority registers
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            irqEnable        <= `RST_IRQ_ENABLE;
            irqPriority      <= `RST_IRQ_PRIORITY;
            secondEnablePrio <= `RST_SECOND_EN_PRIO;
        end else begin
            if (wrEn) begin
                irqEnable <= writedata[7:0];
            end
            if (wrPrio) begin
                irqPriority <= writedata[7:0];
            end
            if (wrSecond) begin
                secondEnablePrio <= writedata[7:0];
            end
        end
    end

    // Timer control: software write first, hardware set wins over clear
    reg [7:0] next_timerControl;
    always @* begin
        next_timerControl = timerControl;
        if (wrTimer) begin
            next_timerControl = writedata[7:0];
        end
        // Auto-clear on entry, timers always, pins only in edge mode
        if (clrTmr0) begin
            next_timerControl[`BIT_TMR0_OVF] = 1'b0;
        end
        if (clrTmr1) begin
            next_timerControl[`BIT_TMR1_OVF] = 1'b0;
        end
        if (clrExt0 && timerControl[`BIT_EXT0_EDGE]) begin
            next_timerControl[`BIT_EXT0_PEND] = 1'b0;
        end
        if (clrExt1 && timerControl[`BIT_EXT1_EDGE]) begin
            next_timerControl[`BIT_EXT1_PEND] = 1'b0;
        end
        // Hardware sets
        if (timer0_overflow) begin
            next_timerControl[`BIT_TMR0_OVF] = 1'b1;
        end
        if (timer1_overflow) begin
            next_timerControl[`BIT_TMR1_OVF] = 1'b1;
        end
        // Level mode tracks the pin; frozen while the core is off
        if (!core_off_power_mode) begin
            if (!next_timerControl[`BIT_EXT0_EDGE]) begin
                next_timerControl[`BIT_EXT0_PEND] = ~pin0Sync;
            end else if (fall0) begin
                next_timerControl[`BIT_EXT0_PEND] = 1'b1;
            end
            if (!next_timerControl[`BIT_EXT1_EDGE]) begin
                next_timerControl[`BIT_EXT1_PEND] = ~pin1Sync;
            end else if (fall1) begin
                next_timerControl[`BIT_EXT1_PEND] = 1'b1;
            end
        end
    end

    // Timer control register
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            timerControl <= `RST_TIMER_CONTROL;
        end else begin
            timerControl <= next_timerControl;
        end
    end

    // Latched requests: wake-up, temperature, serial; set beats clear
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wake0Pend <= 1'b0;
            wake1Pend <= 1'b0;
            tempLatch <= 1'b0;
            serLatch  <= 1'b0;
        end else begin
            // Wake-up keeps its own pending bit, flags untouched
            wake0Pend <= ext_wake0 | (wake0Pend & ~clrExt0);
            wake1Pend <= ext_wake1 | (wake1Pend & ~clrExt1);
            // Only entry clears these; status writes cannot
            tempLatch <= temperature_request | (tempLatch & ~clrTemp);
            serLatch  <= serial_periph_request | (serLatch & ~clrSer);
        end
    end

    // In-service levels, hold-off and latency counter
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            inService <= 3'b000;
            holdOff   <= 1'b0;
            latCount  <= 16'h0000;
        end else begin
            // Entry marks the new level; otherwise a return retires the highest one
            if (takeNow) begin
                inService[winLevel] <= 1'b1;
            end else if (return_from_interrupt) begin
                if (inService[2]) begin
                    inService[2] <= 1'b0;
                end else if (inService[1]) begin
                    inService[1] <= 1'b0;
                end else begin
                    inService[0] <= 1'b0;
                end
            end
            // Set beats the clearing instruction boundary
            if (return_from_interrupt || cfgAccess) begin
                holdOff <= 1'b1;
            end else if (instr_done) begin
                holdOff <= 1'b0;
            end
            // Counts while a request could win; restarts after entry
            if (!outranks || takeNow) begin
                latCount <= 16'h0000;
            end else if (latCount < MIN_LAT[15:0]) begin
                latCount <= latCount + 16'h0001;
            end
        end
    end

    // Vector output to the core sequencer
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            vectorTake <= 1'b0;
            vectorAddr <= 16'h0000;
        end else begin
            // Core pushes only its counter and jumps here
            vectorTake <= takeNow;
            if (takeNow) begin
                vectorAddr <= nextVector;
            end
        end
    end

    // Status readback: pending sources and levels in service
    reg  [NUM_SRC-1:0] visiblePend;
    always @* begin
        visiblePend         = request;
        visiblePend[P_TEMP] = 1'b0;
    end

    // Read mux, unmapped words read as zero
    reg [31:0] next_readdata;
    always @* begin
        next_readdata = 32'h0000_0000;
        if (wordAlign) begin
            case (regIdx)
                `IDX_IRQ_ENABLE:     next_readdata = {24'h000000, irqEnable};
                `IDX_IRQ_PRIORITY:   next_readdata = {24'h000000, irqPriority};
                `IDX_SECOND_EN_PRIO: next_readdata = {24'h000000, secondEnablePrio};
                `IDX_TIMER_CONTROL:  next_readdata = {24'h000000, timerControl};
                `IDX_IRQ_STATUS:     next_readdata = {13'h0000, inService, 3'b000,
                                                      visiblePend};
                default:             next_readdata = 32'h0000_0000;
            endcase
        end
    end

    // Bus handshake: one wait cycle, then a single ready cycle
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            waitrequest <= 1'b1;
            readdata    <= 32'h0000_0000;
        end else begin
            if ((read || write) && waitrequest) begin
                waitrequest <= 1'b0;
                readdata    <= next_readdata;
            end else begin
                // Back to idle; trades throughput for a simple decode path
                waitrequest <= 1'b1;
            end
        end
    end

endmodule

// ==== testbench/irq_priority_sva.sv ====
// Port checker for the interrupt priority unit
module irq_priority_sva (
    input wire        clk,
    input wire        rst_b,
    input wire        read,
    input wire        write,
    input wire        waitrequest,
    input wire        instr_done,
    input wire        return_from_interrupt,
    input wire        vectorTake,
    input wire [15:0] vectorAddr
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    reset_values_a: assert property ($rose(rst_b) |-> waitrequest && vectorAddr == 16'h0)
        else $error("bad state after reset");
    bus_answer_a: assert property ((read || write) && waitrequest |=> !waitrequest)
        else $error("bus not answered");
    wait_single_a: assert property (!waitrequest |=> waitrequest) else $error("long answer");
    take_pulse_a: assert property (vectorTake |=> !vectorTake)
        else $error("long take");
    take_boundary_a: assert property (vectorTake |-> $past(instr_done))
        else $error("take off boundary");
    vec_hold_a: assert property (!vectorTake |-> $stable(vectorAddr))
        else $error("vector moved");
    vec_table_a: assert property (vectorTake |-> vectorAddr[2:0] == 3'h3 && vectorAddr < 16'h64)
        else $error("bad vector");
    ret_holdoff_a: assert property (return_from_interrupt |-> ##2 !vectorTake)
        else $error("take after return");
    power_c: cover property (vectorTake && vectorAddr == 16'h0043);
    ret_c: cover property (return_from_interrupt);
    bus_c: cover property (write && !waitrequest);
endmodule
bind irq_priority_unit irq_priority_sva chk_u (.clk, .rst_b, .read, .write, .waitrequest,
    .instr_done, .return_from_interrupt, .vectorTake, .vectorAddr);

// ==== testbench/core_model.sv ====
// Behavioural core: instruction boundaries and a stack of return addresses
module core_model (
    input  wire        clk,
    input  wire        rst_b,
    input  wire        slow,
    input  wire        retReq,
    input  wire        vectorTake,
    input  wire [15:0] vectorAddr,
    output logic       instr_done = 1'b0,
    output logic       return_from_interrupt = 1'b0
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] pc = 16'h0100, stack[$]; // Only the counter is saved
    logic [1:0]  phase = 2'h0;
    // Slow mode ends an instruction only every fourth cycle
    always @(posedge clk) begin
        phase <= phase + 2'h1;
        instr_done <= rst_b && (!slow || phase == 2'h0);
        return_from_interrupt <= 1'b0;
        pc <= pc + 16'h1;
        if (vectorTake) begin
            stack.push_back(pc);
            pc <= vectorAddr;
        end else if (retReq && stack.size() > 0) begin
            return_from_interrupt <= 1'b1;
            pc <= stack.pop_back();
        end
    end
endmodule

// ==== testbench/mcu_interrupt_priority_unit_tb.sv ====
// Self-checking bench for the interrupt priority unit
module mcu_interrupt_priority_unit_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0, rst_b = 1'b0, read = 1'b0, write = 1'b0, slow = 1'b0;
    logic        retReq = 1'b0, coreOff = 1'b0, wake0 = 1'b0;
    logic [9:0]  address = 10'h0;
    logic [31:0] writedata = 32'h0, seed = 32'h4da9, q;
    logic [12:0] act = 13'h0, pend; // Requests in polling order
    logic [7:0]  prio, second;
    wire  [31:0] readdata;
    wire  [15:0] vectorAddr;
    wire         waitrequest, vectorTake, instr_done, retPulse;
    int          num_errors = 0, n_compared = 0, w;
    int          slotOf[13] = '{8, 10, 9, 11, 6, 0, 1, 2, 3, 7, 4, 5, 12};
    always #2 clk = ~clk;
    irq_priority_unit #(.MIN_LAT(2)) dut_u (.clk, .rst_b, .address, .byteenable(4'h1), .read,
        .write, .writedata, .readdata, .waitrequest, .power_mgmt_flag(act[0]),
        .rtc_alarm_flag(act[1]), .rtc_interval_flag(act[1]), .metering_irq_flag(act[2]),
        .watchdog_timeout_flag(act[3]), .temperature_request(act[4]), .ext_pin0_b(~act[5]),
        .timer0_overflow(act[6]), .ext_pin1_b(~act[7]), .timer1_overflow(act[8]),
        .serial_periph_request(act[9]), .uart_receive_flag(act[10]),
        .uart_transmit_flag(act[10]), .timer2_overflow(act[11]), .timer2_external_flag(act[11]),
        .uart_b_receive_flag(act[12]), .uart_b_transmit_flag(act[12]),
        .core_off_power_mode(coreOff), .ext_wake0(wake0), .ext_wake1(1'b0), .instr_done,
        .return_from_interrupt(retPulse), .vectorTake, .vectorAddr);
    core_model core_u (.clk, .rst_b, .slow, .retReq, .vectorTake, .vectorAddr, .instr_done,
        .return_from_interrupt(retPulse));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        $display("compared %0d errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // Power level first, then high bits, ties to the lower polling index
    function automatic int winner(input logic [12:0] a);
        logic [12:0] hi;
        int b;
        hi = {second[7], prio[5:4], second[4], prio[3:0], prio[6], 1'h0, prio[7], second[6], 1'h0};
        b = -1;
        if (a[0])
            return 0;
        for (int i = 12; i > 0; i--)
            if (a[i] && (b < 0 || hi[i] >= hi[b]))
                b = i;
        return b;
    endfunction
    // Avalon access, held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [9:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        read <= ~wr;
        write <= wr;
        address <= a;
        writedata <= d;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (waitrequest !== 1'b0 && n < 500);
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
        if (n >= 500)
            check(32'h0, 32'h1);
        if (n >= 500)
            print_verdict();
    endtask
    // Wait for a take, compare the vector, drop the source, then return
    task automatic serve(input int p);
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (vectorTake !== 1'b1 && n < 500);
        check({16'h0, vectorAddr}, 32'h3 + 8 * slotOf[p]);
        if (n >= 500)
            check(32'h0, 32'h1);
        if (n >= 500)
            print_verdict();
        act[p] <= 1'b0;
        repeat (8) @(posedge clk);
        retReq <= 1'b1;
        @(posedge clk);
        retReq <= 1'b0;
    endtask
    initial begin
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        bus(1'b0, 10'h2a4, 32'h0);
        check(q, 32'ha0);
        bus(1'b0, 10'h3fc, 32'h0);
        check(q, 32'h0);
        bus(1'b1, 10'h2a0, 32'h7f);
        act <= 13'h0008;
        repeat (40) @(posedge clk);
        check({15'h0, vectorTake, vectorAddr}, 32'h0);
        bus(1'b1, 10'h2a0, 32'hff);
        serve(3);
        for (int k = 0; k < 4; k++) begin
            q = rnd();
            prio = k == 0 ? 8'h00 : q[7:0];
            second = k == 0 ? 8'h2f : {q[15:14], 1'h1, q[12], 4'hf};
            slow <= q[16];
            pend = k == 0 ? 13'h1fff : q[29:17];
            bus(1'b1, 10'h2e0, {24'h0, prio});
            bus(1'b1, 10'h2a4, {24'h0, second});
            bus(1'b0, 10'h2a4, 32'h0);
            check(q, {24'h0, second});
            bus(1'b1, 10'h2a0, 32'h7f);
            act <= pend;
            @(posedge clk);
            act <= pend & ~13'h0350;
            repeat (8) @(posedge clk);
            // Software finds the cause from status; temperature never shows
            bus(1'b0, 10'h320, 32'h0);
            check(q, {19'h0, pend & 13'h1fef});
            bus(1'b1, 10'h2a0, 32'hff);
            while (pend != 13'h0) begin
                w = winner(pend);
                serve(w);
                pend[w] = 1'b0;
            end
        end
        // Edge mode on both pins; a fall while the core is off is lost
        bus(1'b1, 10'h220, 32'h5);
        coreOff <= 1'b1;
        act[5] <= 1'b1;
        repeat (4) @(posedge clk);
        bus(1'b0, 10'h220, 32'h0);
        check(q, 32'h5);
        wake0 <= 1'b1;
        @(posedge clk);
        wake0 <= 1'b0;
        coreOff <= 1'b0;
        serve(5);
        // Fresh falling edge: entry must clear the pending flag
        act[5] <= 1'b1;
        serve(5);
        bus(1'b0, 10'h220, 32'h0);
        check(q, 32'h5);
        print_verdict();
    end
endmodule
